// *** design/irqc_top.sv ***
// Interrupt request/enable registers with low-supply detector control.
// Contract
// - Three-bit trip level select, 000 lowest at 2.0V, 111 highest at 4.0V.
// - Low-supply output flag high while supply below trip level, else low.
// - Detector runs when its enable bit is one, off when cleared.
// - Detector held off in sleep mode whatever its enable bit says.
// - Low-supply request set only after fixed delay following flag going high.
// - New low-supply request wakes from idle; preset flag avoids the wake.
// - Bandgap on when detector on, low-voltage reset on, or buffer bit set.
// - Control register output flag bit 5 read-only, bits 7..6 read zero.
// - Two-bit edge select per pin: off, rising, falling, both.
// - Bit 0 of first primary register is global enable gating all interrupts.
// - Every source has its own read-write enable bit and request flag; groups 0, 1, 2 and 5 mask off sub_evt bit 2, which gets neither.
// - Four primary registers, six group registers, one edge select register.
// - First primary register: pin1, pin0, comparator0 flags, enables, global enable.
// - Second primary: group1, group0, low-supply, serial flags and enables.
// - Low-supply output flag is not filtered and may toggle repeatedly.
// - Sources: two pins, timers, time bases, serial, low-supply, EEPROM, ADC.
// - Flags set on their event even when the source enable is zero.
// Assumes a CPU special-register port on ref_clk and an analogue comparator output.
`timescale 1ns/10ps
module irqc_top (
  input  wire logic            ref_clk,
  input  wire logic            rst,
  input  wire logic [3:0]      sfr_addr,
  input  wire logic            sfr_wr,
  input  wire logic            sfr_rd,
  input  wire logic [7:0]      sfr_wdata,
  output logic      [7:0]      sfr_rdata,
  input  wire logic            ext_pin0,
  input  wire logic            ext_pin1,
  input  wire logic            supply_below_trip,
  input  wire logic            lvr_on,
  input  wire logic            sleep_mode,
  input  wire logic            idle_mode,
  input  wire logic            line_comparator0_evt,
  input  wire logic            line_comparator1_evt,
  input  wire logic            time_base0_evt,
  input  wire logic            time_base1_evt,
  input  wire logic            serial_iface_evt,
  input  wire logic [5:0][2:0] sub_evt,
  output logic      [2:0]      trip_level_select,
  output logic                 low_supply_detector_on,
  output logic                 low_supply_output_flag,
  output logic                 bandgap_on,
  output logic                 cpu_irq,
  output logic                 wake_req
);

  typedef struct packed {
    logic [irqc_pkg::NUM_REGS-1:0][7:0] regs;
    logic [7:0]                         rdata;
    logic [1:0]                         sup_sync;
    logic                               out_flag;
    irqc_pkg::irqc_lvd_st_t             lvd_st;
    logic [irqc_pkg::DLY_CNT_W-1:0]     dly_cnt;
    logic                               wake;
  } irqc_state_t;

  localparam irqc_state_t STATE_RST = '{
    regs:     {irqc_pkg::NUM_REGS{irqc_pkg::REG_RESET}},
    rdata:    8'h00,
    sup_sync: 2'h0,
    out_flag: 1'b0,
    lvd_st:   irqc_pkg::LVD_OFF,
    dly_cnt:  '0,
    wake:     1'b0
  };

  irqc_state_t                        s_reg;
  irqc_state_t                        s_next;
  logic                               pin0_hit;
  logic                               pin1_hit;
  logic                               det_on;
  logic                               lvf_fire;
  logic [5:0]                         grp_pend;
  logic [irqc_pkg::NUM_REGS-1:0][7:0] hw_set;
  logic [7:0]                         wr_val;

  // Pending test for a register holding flags in 7..4 and enables in 3..0
  function automatic logic pend4(input logic [7:0] r);
    pend4 = |(r[7:4] & r[3:0]);
  endfunction : pend4

  // Pin synchronisers and edge selectors
  irqc_pin_edge u_pin0 (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .pin      (ext_pin0),
    .edge_sel (s_reg.regs[irqc_pkg::IDX_EDGE][irqc_pkg::EDGE_PIN0_LSB +: 2]),
    .hit      (pin0_hit)
  );

  irqc_pin_edge u_pin1 (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .pin      (ext_pin1),
    .edge_sel (s_reg.regs[irqc_pkg::IDX_EDGE][irqc_pkg::EDGE_PIN1_LSB +: 2]),
    .hit      (pin1_hit)
  );

  // Detector power: sleep overrides the enable bit
  assign det_on = s_reg.regs[irqc_pkg::IDX_LOW_SUPPLY_CONTROL][irqc_pkg::LOW_SUPPLY_CONTROL_EN_BIT] & ~sleep_mode;

  // Group roll-up: any sub flag with its enable set
  always_comb begin
    for (int g = 0; g < 6; g++) begin
      grp_pend[g] = pend4(s_reg.regs[int'(irqc_pkg::IDX_GRP0) + g]);
    end
  end

  // Next-state logic
  always_comb begin
    s_next      = s_reg;
    s_next.wake = 1'b0;
    lvf_fire    = 1'b0;
    hw_set      = '0;
    wr_val      = 8'h00;

    // Comparator output crosses in through two flops; no filtering on purpose
    s_next.sup_sync = {s_reg.sup_sync[0], supply_below_trip};
    s_next.out_flag = det_on & s_reg.sup_sync[1];

    // Flag must stay high for the whole delay; a drop restarts it
    case (s_reg.lvd_st)
      irqc_pkg::LVD_OFF: begin
        s_next.dly_cnt = '0;
        if (s_reg.out_flag) begin
          s_next.lvd_st = irqc_pkg::LVD_WAIT;
        end
      end
      irqc_pkg::LVD_WAIT: begin
        if (!s_reg.out_flag) begin
          s_next.lvd_st = irqc_pkg::LVD_OFF;
        end else if (s_reg.dly_cnt == irqc_pkg::REQ_DELAY_LAST) begin
          lvf_fire      = 1'b1;
          s_next.lvd_st = irqc_pkg::LVD_FIRED;
        end else begin
          s_next.dly_cnt = s_reg.dly_cnt + 1'b1;
        end
      end
      irqc_pkg::LVD_FIRED: begin
        if (!s_reg.out_flag) begin
          s_next.lvd_st = irqc_pkg::LVD_OFF;
        end
      end
      default: begin
        s_next.lvd_st = irqc_pkg::LVD_OFF;
      end
    endcase

    // Hardware set terms; flags set even with their enable clear
    hw_set[irqc_pkg::IDX_PRI0][irqc_pkg::P0_PIN1_BIT]  = pin1_hit;
    hw_set[irqc_pkg::IDX_PRI0][irqc_pkg::P0_PIN0_BIT]  = pin0_hit;
    hw_set[irqc_pkg::IDX_PRI0][irqc_pkg::P0_COMP0_BIT] = line_comparator0_evt;
    hw_set[irqc_pkg::IDX_PRI1][irqc_pkg::P1_MF1_BIT]   = grp_pend[1];
    hw_set[irqc_pkg::IDX_PRI1][irqc_pkg::P1_MF0_BIT]   = grp_pend[0];
    hw_set[irqc_pkg::IDX_PRI1][irqc_pkg::P1_LVF_BIT]   = lvf_fire;
    hw_set[irqc_pkg::IDX_PRI1][irqc_pkg::P1_SIM_BIT]   = serial_iface_evt;
    hw_set[irqc_pkg::IDX_PRI2][irqc_pkg::P2_COMP1_BIT] = line_comparator1_evt;
    hw_set[irqc_pkg::IDX_PRI2][irqc_pkg::P2_TB1_BIT]   = time_base1_evt;
    hw_set[irqc_pkg::IDX_PRI2][irqc_pkg::P2_TB0_BIT]   = time_base0_evt;
    hw_set[irqc_pkg::IDX_PRI2][irqc_pkg::P2_MF2_BIT]   = grp_pend[2];
    hw_set[irqc_pkg::IDX_PRI3][irqc_pkg::P3_MF3_BIT +: 3] = grp_pend[5:3];
    for (int g = 0; g < 6; g++) begin
      hw_set[int'(irqc_pkg::IDX_GRP0) + g][irqc_pkg::GRP_FLAG_LSB +: 3] = sub_evt[g];
    end

    // Register update: a hardware set wins over a software clear in the same cycle
    for (int i = 0; i < irqc_pkg::NUM_REGS; i++) begin
      wr_val = (sfr_wr && (int'(sfr_addr) == i)) ? sfr_wdata : s_reg.regs[i];
      s_next.regs[i] = (wr_val | hw_set[i]) & irqc_pkg::REG_MASK[i];
    end

    // Wake only on a fresh request; a flag already set by software gives none
    s_next.wake = idle_mode & lvf_fire & ~s_reg.regs[irqc_pkg::IDX_PRI1][irqc_pkg::P1_LVF_BIT];

    // Read path, one cycle after the strobe; unmapped addresses read zero
    if (sfr_rd) begin
      if (sfr_addr == irqc_pkg::IDX_LOW_SUPPLY_CONTROL) begin
        s_next.rdata = s_reg.regs[irqc_pkg::IDX_LOW_SUPPLY_CONTROL];
        s_next.rdata[irqc_pkg::LOW_SUPPLY_CONTROL_OUT_BIT] = s_reg.out_flag;
      end else if (int'(sfr_addr) < irqc_pkg::NUM_REGS) begin
        s_next.rdata = s_reg.regs[sfr_addr];
      end else begin
        s_next.rdata = 8'h00;
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_reg <= STATE_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs
  assign sfr_rdata              = s_reg.rdata;
  assign trip_level_select      = s_reg.regs[irqc_pkg::IDX_LOW_SUPPLY_CONTROL][irqc_pkg::LOW_SUPPLY_CONTROL_LVL_LSB +: 3];
  assign low_supply_detector_on = det_on;
  assign low_supply_output_flag = s_reg.out_flag;
  assign bandgap_on             = s_reg.regs[irqc_pkg::IDX_LOW_SUPPLY_CONTROL][irqc_pkg::LOW_SUPPLY_CONTROL_EN_BIT]
                                | s_reg.regs[irqc_pkg::IDX_LOW_SUPPLY_CONTROL][irqc_pkg::LOW_SUPPLY_CONTROL_BG_BIT]
                                | lvr_on;
  assign wake_req               = s_reg.wake;
  // Global enable gates every pending primary source
  assign cpu_irq = s_reg.regs[irqc_pkg::IDX_PRI0][irqc_pkg::P0_EMI_BIT]
                 & ((|(s_reg.regs[irqc_pkg::IDX_PRI0][6:4] & s_reg.regs[irqc_pkg::IDX_PRI0][3:1]))
                   | pend4(s_reg.regs[irqc_pkg::IDX_PRI1])
                   | pend4(s_reg.regs[irqc_pkg::IDX_PRI2])
                   | pend4(s_reg.regs[irqc_pkg::IDX_PRI3]));

  // Checks on the design's own outputs and internal state
  property p_trip_level;
    @(posedge ref_clk) disable iff (rst)
    sfr_wr && sfr_addr == irqc_pkg::IDX_LOW_SUPPLY_CONTROL |=> trip_level_select == $past(sfr_wdata[2:0]);
  endproperty
  a_trip_level: assert property (p_trip_level) else $error("trip level not taken from write");

  property p_flag_follows;
    @(posedge ref_clk) disable iff (rst)
    det_on && $past(det_on) && $past(supply_below_trip, 3) |-> low_supply_output_flag;
  endproperty
  a_flag_follows: assert property (p_flag_follows) else $error("output flag missed low supply");

  property p_det_off;
    @(posedge ref_clk) disable iff (rst)
    !det_on |=> !low_supply_output_flag;
  endproperty
  a_det_off: assert property (p_det_off) else $error("flag high with detector off");

  property p_sleep_off;
    @(posedge ref_clk) disable iff (rst)
    sleep_mode |-> !low_supply_detector_on;
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("detector on during sleep");

  property p_lvf_delay;
    @(posedge ref_clk) disable iff (rst)
    lvf_fire |-> s_reg.dly_cnt == irqc_pkg::REQ_DELAY_LAST && s_reg.out_flag
             ##1 s_reg.regs[irqc_pkg::IDX_PRI1][irqc_pkg::P1_LVF_BIT];
  endproperty
  a_lvf_delay: assert property (p_lvf_delay) else $error("request set before delay");

  property p_wake;
    @(posedge ref_clk) disable iff (rst)
    idle_mode && lvf_fire && !s_reg.regs[irqc_pkg::IDX_PRI1][irqc_pkg::P1_LVF_BIT] |=> wake_req ##1 !wake_req;
  endproperty
  a_wake: assert property (p_wake) else $error("no single wake pulse");

  property p_bandgap;
    @(posedge ref_clk) disable iff (rst)
    lvr_on || low_supply_detector_on |-> bandgap_on;
  endproperty
  a_bandgap: assert property (p_bandgap) else $error("bandgap off while needed");

  property p_low_supply_control_read;
    @(posedge ref_clk) disable iff (rst)
    sfr_rd && sfr_addr == irqc_pkg::IDX_LOW_SUPPLY_CONTROL |=> sfr_rdata[7:6] == 2'h0
      && sfr_rdata[irqc_pkg::LOW_SUPPLY_CONTROL_OUT_BIT] == $past(low_supply_output_flag);
  endproperty
  a_low_supply_control_read: assert property (p_low_supply_control_read) else $error("control register read wrong");

  property p_global_gate;
    @(posedge ref_clk) disable iff (rst)
    !s_reg.regs[irqc_pkg::IDX_PRI0][irqc_pkg::P0_EMI_BIT] |-> !cpu_irq;
  endproperty
  a_global_gate: assert property (p_global_gate) else $error("irq with global enable off");

  property p_pin_set;
    @(posedge ref_clk) disable iff (rst)
    pin0_hit |=> s_reg.regs[irqc_pkg::IDX_PRI0][irqc_pkg::P0_PIN0_BIT];
  endproperty
  a_pin_set: assert property (p_pin_set) else $error("pin edge lost");

  property p_group_roll;
    @(posedge ref_clk) disable iff (rst)
    grp_pend[0] |=> s_reg.regs[irqc_pkg::IDX_PRI1][irqc_pkg::P1_MF0_BIT];
  endproperty
  a_group_roll: assert property (p_group_roll) else $error("group flag not set");

  // Further guards on the pin, gating, flag and read paths
  property p_pin1_set;
    @(posedge ref_clk) disable iff (rst)
    pin1_hit |=> s_reg.regs[irqc_pkg::IDX_PRI0][irqc_pkg::P0_PIN1_BIT];
  endproperty
  a_pin1_set: assert property (p_pin1_set) else $error("pin1 edge lost");

  property p_edge_off;
    @(posedge ref_clk) disable iff (rst)
    s_reg.regs[irqc_pkg::IDX_EDGE][irqc_pkg::EDGE_PIN0_LSB +: 2] == irqc_pkg::EDGE_OFF |=> !pin0_hit;
  endproperty
  a_edge_off: assert property (p_edge_off) else $error("edge seen on disabled pin");

  property p_irq_raise;
    @(posedge ref_clk) disable iff (rst)
    s_reg.regs[irqc_pkg::IDX_PRI0][irqc_pkg::P0_EMI_BIT] && pend4(s_reg.regs[irqc_pkg::IDX_PRI1]) |-> cpu_irq;
  endproperty
  a_irq_raise: assert property (p_irq_raise) else $error("pending source gave no irq");

  // A drop of the comparator shows three cycles later, as a rise does; nothing smooths the flag
  property p_flag_drop;
    @(posedge ref_clk) disable iff (rst)
    $past(det_on) && !$past(supply_below_trip, 3) |-> !low_supply_output_flag;
  endproperty
  a_flag_drop: assert property (p_flag_drop) else $error("output flag held after supply rose");

  property p_lvf_restart;
    @(posedge ref_clk) disable iff (rst)
    !s_reg.out_flag |=> s_reg.lvd_st == irqc_pkg::LVD_OFF;
  endproperty
  a_lvf_restart: assert property (p_lvf_restart) else $error("delay kept running after drop");

  property p_unmapped_read;
    @(posedge ref_clk) disable iff (rst)
    sfr_rd && int'(sfr_addr) >= irqc_pkg::NUM_REGS |=> sfr_rdata == 8'h00;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

  // Main scenarios
  c_lvf_fire: cover property (@(posedge ref_clk) disable iff (rst) lvf_fire);
  c_wake: cover property (@(posedge ref_clk) disable iff (rst) wake_req);
  c_pin1: cover property (@(posedge ref_clk) disable iff (rst) pin1_hit ##1 cpu_irq);
  c_group: cover property (@(posedge ref_clk) disable iff (rst) grp_pend[3] ##1 cpu_irq);

endmodule : irqc_top

// *** design/irqc_pkg.sv ***
// Constants for the interrupt controller with low-supply detector.
// Assumes a single 25 MHz system clock and a synchronous active-high reset.
package irqc_pkg;

  // System clock
  localparam int CLK_FREQ_MHZ = 25;

  // Delay from low-supply flag rising to the request flag being set
  localparam int REQ_DELAY_NS  = 100000;
  localparam int REQ_DELAY_CYC = (REQ_DELAY_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int DLY_CNT_W     = 12;
  localparam logic [DLY_CNT_W-1:0] REQ_DELAY_LAST = DLY_CNT_W'(REQ_DELAY_CYC - 1);

  // Register indices on the special-register port
  localparam int NUM_REGS = 12;
  localparam logic [3:0] IDX_LOW_SUPPLY_CONTROL = 4'h0;
  localparam logic [3:0] IDX_EDGE = 4'h1;
  localparam logic [3:0] IDX_PRI0 = 4'h2;
  localparam logic [3:0] IDX_PRI1 = 4'h3;
  localparam logic [3:0] IDX_PRI2 = 4'h4;
  localparam logic [3:0] IDX_PRI3 = 4'h5;
  localparam logic [3:0] IDX_GRP0 = 4'h6;

  // Value of every register after reset
  localparam logic [7:0] REG_RESET = 8'h00;

  // Implemented bits per register, index 11 down to 0
  localparam logic [NUM_REGS-1:0][7:0] REG_MASK = {
    8'h33, 8'h77, 8'h77, 8'h33, 8'h33, 8'h33,
    8'h77, 8'hff, 8'hff, 8'h7f, 8'h0f, 8'h1f};

  // Low-supply control fields
  localparam int LOW_SUPPLY_CONTROL_OUT_BIT = 5;
  localparam int LOW_SUPPLY_CONTROL_EN_BIT  = 4;
  localparam int LOW_SUPPLY_CONTROL_BG_BIT  = 3;
  localparam int LOW_SUPPLY_CONTROL_LVL_LSB = 0;

  // Edge selector fields and codes
  localparam int EDGE_PIN1_LSB = 2;
  localparam int EDGE_PIN0_LSB = 0;
  localparam logic [1:0] EDGE_OFF  = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // Primary register bit positions
  localparam int P0_EMI_BIT   = 0;
  localparam int P0_COMP0_BIT = 4;
  localparam int P0_PIN0_BIT  = 5;
  localparam int P0_PIN1_BIT  = 6;
  localparam int P1_SIM_BIT   = 4;
  localparam int P1_LVF_BIT   = 5;
  localparam int P1_MF0_BIT   = 6;
  localparam int P1_MF1_BIT   = 7;
  localparam int P2_MF2_BIT   = 4;
  localparam int P2_TB0_BIT   = 5;
  localparam int P2_TB1_BIT   = 6;
  localparam int P2_COMP1_BIT = 7;
  localparam int P3_MF3_BIT   = 4;
  localparam int GRP_FLAG_LSB = 4;

  // Low-supply request delay states
  typedef enum logic [2:0] {
    LVD_OFF   = 3'b001,
    LVD_WAIT  = 3'b010,
    LVD_FIRED = 3'b100
  } irqc_lvd_st_t;

endpackage : irqc_pkg

// *** design/irqc_pin_edge.sv ***
// External interrupt pin synchroniser and edge selector.
// Assumes the pin is asynchronous to ref_clk; hit is a one-cycle pulse.
`timescale 1ns/10ps
module irqc_pin_edge (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       pin,
  input  wire logic [1:0] edge_sel,
  output logic            hit
);

  typedef struct packed {
    logic [1:0] sync;
    logic       prev;
    logic       hit;
  } irqc_edge_t;

  irqc_edge_t s_reg;
  irqc_edge_t s_next;

  // Two-stage sync, then compare the stable copy with its last value
  always_comb begin
    s_next      = s_reg;
    s_next.sync = {s_reg.sync[0], pin};
    s_next.prev = s_reg.sync[1];
    s_next.hit  = (edge_sel[0] & s_reg.sync[1] & ~s_reg.prev)
                | (edge_sel[1] & ~s_reg.sync[1] & s_reg.prev);
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign hit = s_reg.hit;

endmodule : irqc_pin_edge

// *** verif/irqc_cpu_model.sv ***
// CPU-side special-register master: one write or read per task call.
// Assumes ref_clk from the bench; requests launch on the falling edge.
`timescale 1ns/10ps
module irqc_cpu_model (
  input  wire logic       ref_clk,
  output logic      [3:0] sfr_addr,
  output logic            sfr_wr,
  output logic            sfr_rd,
  output logic      [7:0] sfr_wdata,
  input  wire logic [7:0] sfr_rdata
);
  // Idle bus at time zero
  initial begin
    sfr_addr  = 4'h0;
    sfr_wr    = 1'b0;
    sfr_rd    = 1'b0;
    sfr_wdata = 8'h5a;
  end

  // One-cycle strobe; data inverted once released so a stale byte cannot pass
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_wr    = 1'b1;
    @(negedge ref_clk);
    sfr_wr    = 1'b0;
    sfr_wdata = ~d;
  endtask : wr

  // Read data is registered, so it is taken one edge after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    sfr_addr = a;
    sfr_rd   = 1'b1;
    @(negedge ref_clk);
    sfr_rd   = 1'b0;
    @(negedge ref_clk);
    d = sfr_rdata;
  endtask : rd
endmodule : irqc_cpu_model

// *** verif/irq_ctrl_with_low_supply_detect_tb.sv ***
// Self-checking bench for the interrupt controller with low-supply detector.
// Assumes the CPU model drives the register port; a register-array model predicts.
`timescale 1ns/10ps
module irq_ctrl_with_low_supply_detect_tb;
  logic            ref_clk, rst, ext_pin0, ext_pin1, supply_below_trip, lvr_on;
  logic            sleep_mode, idle_mode, lc0, lc1, tb0, tb1, ser;
  logic [3:0]      sfr_addr;
  logic            sfr_wr, sfr_rd;
  logic [7:0]      sfr_wdata, sfr_rdata, d;
  logic [5:0][2:0] sub_evt;
  logic [2:0]      trip_level_select;
  logic            low_supply_detector_on, low_supply_output_flag, bandgap_on, cpu_irq, wake_req;
  logic [7:0]      mdl [16];
  int              errors, samples_checked, wake_cnt, i;

  irqc_top i_dut (.ref_clk(ref_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .ext_pin0(ext_pin0), .ext_pin1(ext_pin1),
    .supply_below_trip(supply_below_trip), .lvr_on(lvr_on), .sleep_mode(sleep_mode), .idle_mode(idle_mode),
    .line_comparator0_evt(lc0), .line_comparator1_evt(lc1), .time_base0_evt(tb0), .time_base1_evt(tb1),
    .serial_iface_evt(ser), .sub_evt(sub_evt), .trip_level_select(trip_level_select),
    .low_supply_detector_on(low_supply_detector_on), .low_supply_output_flag(low_supply_output_flag),
    .bandgap_on(bandgap_on), .cpu_irq(cpu_irq), .wake_req(wake_req));

  irqc_cpu_model i_cpu (.ref_clk(ref_clk), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata));

  // 25 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // Wake pulses are counted so a missing or extra one shows later
  always @(posedge ref_clk) if (wake_req === 1'b1) wake_cnt <= wake_cnt + 1;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // Unmapped places keep nothing; mapped ones keep only implemented bits
  task automatic wreg(input int a, input logic [7:0] v);
    i_cpu.wr(4'(a), v);
    mdl[a] = (a < 12) ? (v & irqc_pkg::REG_MASK[a]) : 8'h00;
  endtask : wreg

  task automatic rreg(input int a);
    i_cpu.rd(4'(a), d);
    chk(d, mdl[a]);
  endtask : rreg

  // Processor request predicted from the model registers
  function automatic logic f_irq();
    logic p;
    p = |(mdl[2][6:4] & mdl[2][3:1]);
    for (int r = 3; r < 6; r++) p = p | (|(mdl[r][7:4] & mdl[r][3:0]));
    return p & mdl[2][0];
  endfunction : f_irq

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim

  // Hang guard
  initial begin
    #3000000;
    errors++;
    $display("unexpected at %0t: timeout", $time);
    end_sim();
  end

  initial begin
    errors = 0;
    samples_checked = 0;
    wake_cnt = 0;
    rst = 1'b1;
    {ext_pin0, ext_pin1, supply_below_trip, lvr_on, sleep_mode, idle_mode} = '0;
    {lc0, lc1, tb0, tb1, ser} = '0;
    sub_evt = '0;
    for (i = 0; i < 16; i++) mdl[i] = 8'h00;
    void'($urandom(32'h609ae32b));
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    for (i = 0; i < 16; i++) rreg(i);
    $display("test reset done");
    // Random fill; group flags left clear so primary readback stays exact
    for (i = 0; i < 16; i++) wreg(i, (i >= 6 && i < 12) ? 8'($urandom & 32'h0000000f) : 8'($urandom));
    for (i = 0; i < 16; i++) rreg(i);
    chk(cpu_irq, f_irq());
    chk(trip_level_select, mdl[0][2:0]);
    chk(bandgap_on, mdl[0][4] | mdl[0][3]);
    for (i = 15; i >= 0; i--) wreg(i, 8'h00);
    $display("test registers done");
    // Every edge code on both pins, pin1 taking the complement code
    for (i = 0; i < 4; i++) begin
      wreg(1, 8'((3 - i) << 2 | i));
      @(negedge ref_clk);
      {ext_pin1, ext_pin0} = 2'b11;
      repeat (8) @(negedge ref_clk);
      mdl[2] = {1'b0, ~i[0], i[0], 5'h00};
      rreg(2);
      wreg(2, 8'h00);
      {ext_pin1, ext_pin0} = 2'b00;
      repeat (8) @(negedge ref_clk);
      mdl[2] = {1'b0, ~i[1], i[1], 5'h00};
      rreg(2);
      wreg(2, 8'h00);
    end
    $display("test pins done");
    // Events with primary enables off still set their flags; the group 0 sub enable is on for the roll-up
    wreg(6, 8'h01);
    @(negedge ref_clk);
    {lc0, ser} = 2'b11;
    sub_evt[0][0] = 1'b1;
    @(negedge ref_clk);
    {lc0, ser} = 2'b00;
    sub_evt = '0;
    repeat (2) @(negedge ref_clk);
    mdl[2] = 8'h10;
    mdl[3] = 8'h50;
    mdl[6] = 8'h11;
    for (i = 2; i < 7; i += 4) rreg(i);
    rreg(3);
    chk(cpu_irq, 1'b0);
    wreg(2, 8'h11);
    chk(cpu_irq, f_irq());
    wreg(3, 8'h54);
    rreg(3);
    chk(cpu_irq, f_irq());
    for (i = 15; i >= 0; i--) wreg(i, 8'h00);
    $display("test events done");
    // Low-supply path, held in idle throughout
    idle_mode = 1'b1;
    lvr_on = 1'b1;
    @(negedge ref_clk);
    chk(bandgap_on, 1'b1);
    lvr_on = 1'b0;
    wreg(0, 8'h17);
    chk(low_supply_detector_on, 1'b1);
    chk(trip_level_select, 3'h7);
    sleep_mode = 1'b1;
    @(negedge ref_clk);
    chk(low_supply_detector_on, 1'b0);
    sleep_mode = 1'b0;
    repeat (20) @(negedge ref_clk);
    supply_below_trip = 1'b1;
    repeat (5) @(negedge ref_clk);
    chk(low_supply_output_flag, 1'b1);
    supply_below_trip = 1'b0;
    repeat (5) @(negedge ref_clk);
    chk(low_supply_output_flag, 1'b0);
    supply_below_trip = 1'b1;
    repeat (2400) @(negedge ref_clk);
    rreg(3);
    repeat (200) @(negedge ref_clk);
    mdl[3] = 8'h20;
    rreg(3);
    chk(8'(wake_cnt), 8'h01);
    supply_below_trip = 1'b0;
    repeat (5) @(negedge ref_clk);
    supply_below_trip = 1'b1;
    repeat (2700) @(negedge ref_clk);
    chk(8'(wake_cnt), 8'h01);
    $display("test low supply done");
    end_sim();
  end
endmodule : irq_ctrl_with_low_supply_detect_tb
